// ===== inc/rsq_pkg.sv
// types used by the reset sequencer; its bench does not import them
// assumes rsq_regs.svh supplies the numeric constants
package rsq_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RSQ_HOLD = 3'b001,
    RSQ_WAIT = 3'b010,
    RSQ_RUN  = 3'b100
  } rsq_state_t;

endpackage : rsq_pkg

// ===== inc/rsq_regs.svh
// constants for the reset sequencer: register map, fields, timing counts
// assumes a 20 MHz reference clock and a 4-bit register port
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH

// ----------------------------------------------------------------
// register map (4-bit address, 4-bit data)
// ----------------------------------------------------------------
`define RSQ_ADDR_STATUS   4'h0
`define RSQ_ADDR_WDT_SEL  4'h2
`define RSQ_ADDR_WDT_CLR  4'h3

// status fields
`define RSQ_ST_CAUSE_BIT  0
`define RSQ_ST_RUN_BIT    1
`define RSQ_ST_THR_BIT    2
`define RSQ_ST_CEP_BIT    3

// watchdog clear flag position
`define RSQ_CLR_BIT       3

// interval select codes
`define RSQ_SEL_OFF       2'h0
`define RSQ_SEL_SHORT     2'h1
`define RSQ_SEL_BAD       2'h2
`define RSQ_SEL_LONG      2'h3
`define RSQ_SEL_RESET     2'h3

// watchdog terminal counts (interval minus one)
`define RSQ_WDT_W          18
`define RSQ_WDT_SHORT_LAST 18'h0ffff
`define RSQ_WDT_LONG_LAST  18'h1ffff

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RSQ_CLK_HZ        20000000
`define RSQ_CARRY_MS      100
`define RSQ_START_MS      50
`define RSQ_TSET_HALF_MS  50
`define RSQ_CARRY_CYC     (`RSQ_CARRY_MS * (`RSQ_CLK_HZ / 1000))
`define RSQ_START_CYC     (`RSQ_START_MS * (`RSQ_CLK_HZ / 1000))
`define RSQ_HALF_CYC      (`RSQ_TSET_HALF_MS * (`RSQ_CLK_HZ / 1000))

`endif

// ===== rtl/rsq_reset_sequencer.sv
// reset sequencer with watchdog for a small tuning controller
// assumes all inputs synchronous to ref_clk_in; the controller clock
// itself keeps running, osc_enable_out gates the crystal for the core
`include "rsq_regs.svh"

module rsq_reset_sequencer #(
  parameter int CARRY_CYC = `RSQ_CARRY_CYC,
  parameter int START_CYC = `RSQ_START_CYC,
  parameter int HALF_CYC  = `RSQ_HALF_CYC,
  parameter int CNT_W     = 21
) (
  input  wire logic       ref_clk_in,       // controller clock
  input  wire logic       resetn_in,        // async reset, low
  input  wire logic       power_on_clear_signal_in, // detector out
  input  wire logic       reset_pin_n_in,   // reset pin, low
  input  wire logic       chip_enable_in,   // chip-enable pin
  input  wire logic       clock_stop_in,    // core stop pulse
  input  wire logic       halt_in,          // core halt level
  input  wire logic       ext_int_in,       // interrupt pin
  input  wire logic       wake_port_in,     // wake port level
  input  wire logic       instr_in,         // one per instr
  input  wire logic [3:0] addr_in,          // register address
  input  wire logic [3:0] wdata_in,         // write data
  input  wire logic       wr_in,            // write strobe
  input  wire logic       rd_in,            // read strobe
  output logic      [3:0] rdata_out,        // read data
  output logic            osc_enable_out,   // crystal enable
  output logic            core_init_out,    // full init level
  output logic            wdt_init_out,     // partial init pulse
  output logic            start_out,        // start at 0 pulse
  output logic            run_out,          // executing level
  output logic            carry_set_out,    // carry set pulse
  output logic            thr_low_out,      // low threshold
  output logic            stop_release_out  // wake pulse
);

  // ----------------------------------------------------------------
  // constants and helpers
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CARRY_LAST =
    CNT_W'(CARRY_CYC - 1);
  localparam logic [CNT_W-1:0] START_LOAD =
    CNT_W'(CARRY_CYC - START_CYC);
  localparam logic [CNT_W-1:0] HALF_LOAD = CNT_W'(HALF_CYC);
  localparam int               WDT_W     = `RSQ_WDT_W;
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
  localparam logic [WDT_W-1:0] WDT_ONE   = WDT_W'(1);

  function automatic logic wdt_on(input logic [1:0] sel);
    // the prohibited code is treated like disabled
    wdt_on = (sel == `RSQ_SEL_SHORT) || (sel == `RSQ_SEL_LONG);
  endfunction : wdt_on

  function automatic logic [`RSQ_WDT_W-1:0] wdt_last(
    input logic [1:0] sel
  );
    if (sel == `RSQ_SEL_SHORT)
      wdt_last = `RSQ_WDT_SHORT_LAST;
    else
      wdt_last = `RSQ_WDT_LONG_LAST;
  endfunction : wdt_last

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  rsq_pkg::rsq_state_t   state_reg;
  rsq_pkg::rsq_state_t   state_next;
  logic                  hold_req;
  logic [CNT_W-1:0]      carry_cnt_reg;
  logic                  carry_set_reg;
  logic                  stopped_reg;
  logic                  wake_evt;
  logic [CNT_W-1:0]      win_cnt_reg;
  logic                  thr_low_reg;
  logic                  ce_prev_reg;
  logic                  ce_rise;
  logic                  ce_pend_reg;
  logic [1:0]            sel_reg;
  logic                  sel_done_reg;
  logic [`RSQ_WDT_W-1:0] wdt_cnt_reg;
  logic                  wdt_run;
  logic                  wdt_fire;
  logic                  wdt_init_reg;
  logic                  cause_reg;
  logic                  clr_wr;
  logic                  stat_rd;
  logic                  start_reg;
  logic                  run_reg;
  logic                  init_reg;
  logic                  osc_reg;
  logic                  rel_reg;
  logic [3:0]            rdata_reg;

  // ----------------------------------------------------------------
  // reset sources and sequencing
  // ----------------------------------------------------------------
  // detector wins over everything, chip-enable included
  assign hold_req = power_on_clear_signal_in
                  || !reset_pin_n_in;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      rsq_pkg::RSQ_HOLD:
      begin
        if (!hold_req)
          state_next = rsq_pkg::RSQ_WAIT;
      end
      rsq_pkg::RSQ_WAIT:
      begin
        if (carry_set_reg)
          state_next = rsq_pkg::RSQ_RUN;
      end
      rsq_pkg::RSQ_RUN:
      begin
        state_next = rsq_pkg::RSQ_RUN;
      end
      default:
      begin
        state_next = rsq_pkg::RSQ_HOLD;
      end
    endcase
    if (hold_req)
      state_next = rsq_pkg::RSQ_HOLD;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      state_reg <= rsq_pkg::RSQ_HOLD;
    else
      state_reg <= state_next;
  end

  // level outputs follow the next state so they leave a flop
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      init_reg <= 1'b1;
      run_reg  <= 1'b0;
      osc_reg  <= 1'b0;
    end
    else
    begin
      init_reg <= (state_next == rsq_pkg::RSQ_HOLD);
      run_reg  <= (state_next == rsq_pkg::RSQ_RUN);
      // crystal off in hold and while clock stopped
      osc_reg  <= (state_next != rsq_pkg::RSQ_HOLD)
                && !(stopped_reg && !wake_evt)
                && !clock_stop_in;
    end
  end

  // ----------------------------------------------------------------
  // basic timer 0 carry
  // ----------------------------------------------------------------
  // preset on release so the first set edge comes half a period on;
  // a watchdog reset leaves this counter alone
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      carry_cnt_reg <= START_LOAD;
      carry_set_reg <= 1'b0;
    end
    else if (state_reg == rsq_pkg::RSQ_HOLD)
    begin
      carry_cnt_reg <= START_LOAD;
      carry_set_reg <= 1'b0;
    end
    else if (stopped_reg)
    begin
      carry_set_reg <= 1'b0;
    end
    else if (carry_cnt_reg == CARRY_LAST)
    begin
      carry_cnt_reg <= '0;
      carry_set_reg <= 1'b1;
    end
    else
    begin
      carry_cnt_reg <= carry_cnt_reg + CNT_ONE;
      carry_set_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // clock stop, wake and detector threshold
  // ----------------------------------------------------------------
  assign wake_evt = stopped_reg && (ext_int_in || wake_port_in);

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      stopped_reg <= 1'b0;
    else if (state_reg == rsq_pkg::RSQ_HOLD)
      stopped_reg <= 1'b0;
    else if (wake_evt)
      stopped_reg <= 1'b0;
    else if (clock_stop_in && state_reg == rsq_pkg::RSQ_RUN)
      stopped_reg <= 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rel_reg <= 1'b0;
    else
      rel_reg <= wake_evt;
  end

  // threshold stays low for half a setting time after wake, so the
  // supply has that long to climb before a clear can trip
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      win_cnt_reg <= '0;
    else if (state_reg == rsq_pkg::RSQ_HOLD)
      win_cnt_reg <= '0;
    else if (wake_evt)
      win_cnt_reg <= HALF_LOAD;
    else if (win_cnt_reg != '0)
      win_cnt_reg <= win_cnt_reg - CNT_ONE;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      thr_low_reg <= 1'b0;
    else
      thr_low_reg <= (stopped_reg && !wake_evt)
                   || wake_evt
                   || (win_cnt_reg > CNT_W'(1));
  end

  // ----------------------------------------------------------------
  // chip-enable reset
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ce_prev_reg <= 1'b0;
    else
      ce_prev_reg <= chip_enable_in;
  end

  assign ce_rise = chip_enable_in && !ce_prev_reg;

  // rises before execution are swallowed by the pending start
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ce_pend_reg <= 1'b0;
    // a full reset beats a CE edge seen in the same cycle
    else if (state_reg != rsq_pkg::RSQ_RUN || hold_req)
      ce_pend_reg <= 1'b0;
    else if ((ce_rise && !stopped_reg) || wake_evt)
      ce_pend_reg <= 1'b1;
    else if (carry_set_reg)
      ce_pend_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // start at address zero
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      start_reg <= 1'b0;
    else if (hold_req)
      start_reg <= 1'b0;
    else
      start_reg <= (state_reg == rsq_pkg::RSQ_WAIT
                    && carry_set_reg)
                 || (state_reg == rsq_pkg::RSQ_RUN
                    && ce_pend_reg && carry_set_reg)
                 || wdt_fire;
  end

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  assign clr_wr  = wr_in && (addr_in == `RSQ_ADDR_WDT_CLR)
                 && wdata_in[`RSQ_CLR_BIT];
  assign stat_rd = rd_in && (addr_in == `RSQ_ADDR_STATUS);

  // ----------------------------------------------------------------
  // watchdog interval select
  // ----------------------------------------------------------------
  // only full resets re-arm the single write
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sel_reg      <= `RSQ_SEL_RESET;
      sel_done_reg <= 1'b0;
    end
    else if (state_reg == rsq_pkg::RSQ_HOLD)
    begin
      sel_reg      <= `RSQ_SEL_RESET;
      sel_done_reg <= 1'b0;
    end
    else if (wr_in && addr_in == `RSQ_ADDR_WDT_SEL
             && !sel_done_reg)
    begin
      sel_reg      <= wdata_in[1:0];
      sel_done_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  assign wdt_run = (state_reg == rsq_pkg::RSQ_RUN)
                 && !stopped_reg && !halt_in
                 && wdt_on(sel_reg)
                 && instr_in;

  // firmware must clear before the terminal count
  assign wdt_fire = wdt_run && !clr_wr && !hold_req
                  && (wdt_cnt_reg == wdt_last(sel_reg));

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wdt_cnt_reg <= '0;
    else if (state_reg == rsq_pkg::RSQ_HOLD)
      wdt_cnt_reg <= '0;
    else if (clr_wr)
      wdt_cnt_reg <= '0;
    else if (wdt_fire)
      wdt_cnt_reg <= '0;
    else if (wdt_run)
      wdt_cnt_reg <= wdt_cnt_reg + WDT_ONE;
  end

  // partial init: select, clear flag, carry and CE state untouched
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wdt_init_reg <= 1'b0;
    else
      wdt_init_reg <= wdt_fire;
  end

  // read-clear flag; a new expiry beats a same-cycle read
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      cause_reg <= 1'b0;
    else if (wdt_fire)
      cause_reg <= 1'b1;
    else if (state_reg == rsq_pkg::RSQ_HOLD)
      cause_reg <= 1'b0;
    else if (stat_rd)
      cause_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_reg <= 4'h0;
    else if (!rd_in)
      rdata_reg <= 4'h0;
    else
    begin
      unique case (addr_in)
        `RSQ_ADDR_STATUS:
          rdata_reg <= {ce_pend_reg, thr_low_reg,
                        run_reg, cause_reg};
        `RSQ_ADDR_WDT_SEL:
          rdata_reg <= {2'h0, sel_reg};
        default:
          rdata_reg <= 4'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_out        = rdata_reg;
  assign osc_enable_out   = osc_reg;
  assign core_init_out    = init_reg;
  assign wdt_init_out     = wdt_init_reg;
  assign start_out        = start_reg;
  assign run_out          = run_reg;
  assign carry_set_out    = carry_set_reg;
  assign thr_low_out      = thr_low_reg;
  assign stop_release_out = rel_reg;

endmodule : rsq_reset_sequencer

// ===== tb/rsq_firmware_model.sv
// firmware stand-in: one instruction per cycle while the core runs
// assumes the sequencer's run level and clock
module rsq_firmware_model (
  input  wire logic ref_clk_in, // clock
  input  wire logic resetn_in,  // reset, low
  input  wire logic run_in,     // core running
  output logic      instr_out   // instr pulse
);
  // ----------------------------------------------------------------
  // instruction stream
  // ----------------------------------------------------------------
  // never clears the watchdog itself: the bench decides when to clear
  always_ff @(posedge ref_clk_in or negedge resetn_in)
    if (!resetn_in)
      instr_out <= 1'h0;
    else
      instr_out <= run_in;
endmodule : rsq_firmware_model

// ===== tb/rsq_reset_sequencer_bench.sv
// self-checking bench for the reset sequencer
// assumes shortened carry and start counts and a 20 MHz clock
`include "rsq_regs.svh"
module rsq_reset_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CARRY = 8;
  localparam int START = 4;
  logic ref_clk_in = 1'h0, resetn_in = 1'h0, power_on_clear_signal_in = 1'h0;
  logic reset_pin_n_in = 1'h1, chip_enable_in = 1'h0, clock_stop_in = 1'h0;
  logic halt_in = 1'h0, ext_int_in = 1'h0, wake_port_in = 1'h0;
  logic wr_in = 1'h0, rd_in = 1'h0, mark = 1'h0, rd_prev = 1'h0, instr_in;
  logic [3:0] addr_in = 4'h0, wdata_in = 4'h0, rdata_out;
  logic osc_enable_out, core_init_out, wdt_init_out, start_out, run_out;
  logic carry_set_out, thr_low_out, stop_release_out;
  logic [31:0] seed = 32'h8577, r;
  logic [31:0] sq[$], rq[$];
  int err_total = 0, num_checks = 0, since = 0;

  rsq_reset_sequencer #(.CARRY_CYC(CARRY), .START_CYC(START), .HALF_CYC(4))
    u_rsq_reset_sequencer (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .power_on_clear_signal_in(power_on_clear_signal_in),
    .reset_pin_n_in(reset_pin_n_in), .chip_enable_in(chip_enable_in),
    .clock_stop_in(clock_stop_in), .halt_in(halt_in),
    .ext_int_in(ext_int_in), .wake_port_in(wake_port_in),
    .instr_in(instr_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .osc_enable_out(osc_enable_out), .core_init_out(core_init_out),
    .wdt_init_out(wdt_init_out), .start_out(start_out), .run_out(run_out),
    .carry_set_out(carry_set_out), .thr_low_out(thr_low_out),
    .stop_release_out(stop_release_out));
  rsq_firmware_model u_rsq_firmware_model (.ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in), .run_in(run_out), .instr_out(instr_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic arm(int exp);
    sq.push_back(exp);
    mark <= 1'h1;
  endtask : arm
  task automatic wr(logic [3:0] a, logic [3:0] d, int exp = -1);
    @(posedge ref_clk_in);
    if (exp >= 0)
      arm(exp);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge ref_clk_in);
    wr_in <= 1'h0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [3:0] exp);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'h1;
    rq.push_back({28'h0, exp});
    @(posedge ref_clk_in);
    rd_in <= 1'h0;
  endtask : rd
  // bounded wait; a missing pulse ends the run at once
  task automatic wait_hi(ref logic sig, input int bound);
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk_in);
      n++;
    end
    while (sig !== 1'h1 && n < bound);
    if (sig !== 1'h1)
    begin
      check("pulse wait", 32'h0, 32'h1);
      give_verdict();
    end
  endtask : wait_hi

  // ----------------------------------------------------------------
  // result watcher, samples mid-cycle
  // ----------------------------------------------------------------
  always @(negedge ref_clk_in)
  begin
    if (mark)
    begin
      since = 0;
      mark = 1'h0;
    end
    else
      since++;
    if (start_out === 1'h1 && sq.size() > 0)
      check("start delay", since, sq.pop_front());
    if (rd_prev)
      check("read data", {28'h0, rdata_out}, rq.pop_front());
    rd_prev = rd_in;
  end

  initial
    forever #25 ref_clk_in = ~ref_clk_in;

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk_in);
    arm(START + 2);
    resetn_in <= 1'h1;
    wait_hi(start_out, 20);
    rd(`RSQ_ADDR_WDT_SEL, `RSQ_SEL_RESET);
    wr(`RSQ_ADDR_WDT_SEL, 4'h1);
    wr(`RSQ_ADDR_WDT_SEL, 4'h0);
    rd(`RSQ_ADDR_WDT_SEL, 4'h1);
    r = rnd();
    rd({1'h0, r[2:0]} + 4'h4, 4'h0);
    rd(`RSQ_ADDR_WDT_CLR, 4'h0);
    wr(`RSQ_ADDR_WDT_CLR, {1'h0, r[6:4]});
    wr(`RSQ_ADDR_WDT_CLR, 4'h8, 65545);
    halt_in <= 1'h1;
    repeat (8) @(posedge ref_clk_in);
    halt_in <= 1'h0;
    wait_hi(start_out, 70000);
    rd(`RSQ_ADDR_STATUS, 4'h3);
    rd(`RSQ_ADDR_STATUS, 4'h2);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk_in);
      power_on_clear_signal_in <= (i == 0);
      reset_pin_n_in <= (i == 0);
      chip_enable_in <= (i == 1);
      rd(`RSQ_ADDR_STATUS, 4'h0);
      rd(`RSQ_ADDR_WDT_SEL, `RSQ_SEL_RESET);
      @(posedge ref_clk_in);
      arm(START + 2);
      power_on_clear_signal_in <= 1'h0;
      reset_pin_n_in <= 1'h1;
      wait_hi(start_out, 20);
    end
    @(posedge ref_clk_in);
    chip_enable_in <= 1'h0;
    @(posedge ref_clk_in);
    chip_enable_in <= 1'h1;
    arm(CARRY - 2);
    @(posedge ref_clk_in);
    rd(`RSQ_ADDR_STATUS, 4'ha);
    wait_hi(start_out, CARRY + 2);
    rd(`RSQ_ADDR_STATUS, 4'h2);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk_in);
      clock_stop_in <= 1'h1;
      @(posedge ref_clk_in);
      clock_stop_in <= 1'h0;
      rd(`RSQ_ADDR_STATUS, 4'h6);
      @(posedge ref_clk_in);
      ext_int_in <= (i == 0);
      wake_port_in <= (i == 1);
      wait_hi(stop_release_out, 5);
      @(posedge ref_clk_in);
      ext_int_in <= 1'h0;
      wake_port_in <= 1'h0;
      wait_hi(start_out, CARRY + 4);
      repeat (6) @(posedge ref_clk_in);
      rd(`RSQ_ADDR_STATUS, 4'h2);
    end
    repeat (4) @(posedge ref_clk_in);
    give_verdict();
  end
endmodule : rsq_reset_sequencer_bench

// ===== tb/rsq_reset_sequencer_monitor.sv
// checker for the reset sequencer: timing relations at its ports
// assumes one clock domain, asynchronous active-low reset
`include "rsq_regs.svh"
module rsq_reset_sequencer_monitor (
  input wire logic       ref_clk_in,               // clock
  input wire logic       resetn_in,                // reset, low
  input wire logic       power_on_clear_signal_in, // detector
  input wire logic       reset_pin_n_in,           // reset pin
  input wire logic       clock_stop_in,            // stop pulse
  input wire logic       halt_in,                  // halt level
  input wire logic       ext_int_in,               // wake pin
  input wire logic       wake_port_in,             // wake port
  input wire logic       instr_in,                 // instr pulse
  input wire logic [3:0] addr_in,                  // address
  input wire logic [3:0] wdata_in,                 // write data
  input wire logic       wr_in,                    // write strobe
  input wire logic       osc_enable_out,           // crystal on
  input wire logic       core_init_out,            // full init
  input wire logic       wdt_init_out,             // partial init
  input wire logic       start_out,                // start pulse
  input wire logic       run_out,                  // running
  input wire logic       carry_set_out,            // carry edge
  input wire logic       thr_low_out,              // low threshold
  input wire logic       stop_release_out          // wake pulse
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  poc_halts_a: assert property (
    power_on_clear_signal_in |=> !osc_enable_out && core_init_out && !run_out)
    else $error("clear did not halt the core");
  pin_halts_a: assert property (
    !reset_pin_n_in |=> !osc_enable_out && core_init_out && !run_out)
    else $error("reset pin did not halt the core");
  start_carry_a: assert property (
    $rose(run_out) |-> start_out && $past(carry_set_out))
    else $error("run began off the carry edge");
  start_cause_a: assert property (
    start_out |-> $past(carry_set_out) || wdt_init_out)
    else $error("start without carry or watchdog");
  wdt_start_a: assert property (
    wdt_init_out |-> start_out && !core_init_out)
    else $error("watchdog init without restart");
  wdt_idle_a: assert property (
    wdt_init_out |-> $past(instr_in) && $past(run_out) && !$past(halt_in))
    else $error("watchdog fired while idle");
  stop_thr_a: assert property (
    clock_stop_in && run_out && reset_pin_n_in && !power_on_clear_signal_in
    |-> ##2 thr_low_out)
    else $error("threshold not lowered in stop");
  wake_osc_a: assert property (
    stop_release_out |-> osc_enable_out && $past(ext_int_in || wake_port_in))
    else $error("wake without cause or clock");
  clr_wins_a: assert property (
    wr_in && addr_in == `RSQ_ADDR_WDT_CLR && wdata_in[`RSQ_CLR_BIT]
    |=> !wdt_init_out)
    else $error("watchdog fired despite clear");
endmodule : rsq_reset_sequencer_monitor

bind rsq_reset_sequencer rsq_reset_sequencer_monitor
  u_rsq_reset_sequencer_monitor (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
  .power_on_clear_signal_in(power_on_clear_signal_in),
  .reset_pin_n_in(reset_pin_n_in), .clock_stop_in(clock_stop_in),
  .halt_in(halt_in), .ext_int_in(ext_int_in), .wake_port_in(wake_port_in),
  .instr_in(instr_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .osc_enable_out(osc_enable_out),
  .core_init_out(core_init_out), .wdt_init_out(wdt_init_out),
  .start_out(start_out), .run_out(run_out),
  .carry_set_out(carry_set_out), .thr_low_out(thr_low_out),
  .stop_release_out(stop_release_out));
